// *** hdl/pdpwm_top.sv ***
/*
  Pulse-division 14-bit PWM with an Avalon-MM register slave.
  Assumes a single 50 MHz clock, a synchronous active-low reset and an
  Avalon-MM master that holds each request until waitrequest is seen low.
  The shared pin mux lives outside; o_pwm is the generator's own output.
*/
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "pdpwm_cfg.svh"

module pdpwm_top
  import pdpwm_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_reset_n,
  input  wire pdpwm_avs_req_s  i_avs,
  output logic                 o_avs_waitrequest,
  output logic [31:0]          o_avs_readdata,
  output logic                 o_pwm
);

  // ========================================================================
  // Declarations
  logic                          wait_reg;
  logic                          wait_next;
  logic [31:0]                   readdata_reg;
  logic [31:0]                   readdata_next;
  logic                          period_select_reg;
  logic                          period_select_next;
  logic [`PDPWM_DUTY_UPPER_W-1:0] duty_upper_reg;
  logic [`PDPWM_DUTY_UPPER_W-1:0] duty_upper_next;
  logic [7:0]                    duty_lower_reg;
  logic [7:0]                    duty_lower_next;
  pdpwm_duty_t                   pending_duty_reg;
  pdpwm_duty_t                   pending_duty_next;
  logic                          pending_reg;
  logic                          pending_next;
  pdpwm_duty_t                   active_duty_reg;
  pdpwm_duty_t                   active_duty_next;
  logic                          active_sel_reg;
  logic                          active_sel_next;
  pdpwm_duty_t                   unit_cnt_reg;
  pdpwm_duty_t                   unit_cnt_next;
  logic                          pwm_reg;
  logic                          pwm_next;
  logic                          unit_tick;
  logic                          input_clk;
  logic                          boundary;
  logic                          req;
  logic                          fire;
  logic                          wr_fire;
  logic                          hit_ctrl;
  logic                          hit_upper;
  logic                          hit_lower;
  logic                          hit_status;
  logic                          wr_ctrl;
  logic                          wr_upper;
  logic                          wr_lower;
  logic [`PDPWM_PULSE_IDX_W-1:0] pulse_idx;
  logic [`PDPWM_PULSE_IDX_W-1:0] pulse_rev;
  logic [`PDPWM_SLOT_W-1:0]      slot;
  logic [8:0]                    base_width;
  logic                          extra_unit;
  logic [9:0]                    pulse_width;
  logic [31:0]                   status_word;

  // Full reset patterns; only the stored bits are taken from them
  localparam logic [7:0] CTRL_RESET  = `PDPWM_CLOCK_CONTROL_RESET;
  localparam logic [7:0] UPPER_RESET = `PDPWM_DUTY_UPPER_RESET;

  // ========================================================================
  // Bus decode; registers sit in byte lane 0, one aligned word each
  assign req        = i_avs.read | i_avs.write;
  assign fire       = req & ~wait_reg;
  assign wr_fire    = fire & i_avs.write & i_avs.byteenable[0];
  assign hit_ctrl   = i_avs.address == {`PDPWM_IDX_CLOCK_CONTROL, 2'b00};
  assign hit_upper  = i_avs.address == {`PDPWM_IDX_DUTY_UPPER, 2'b00};
  assign hit_lower  = i_avs.address == {`PDPWM_IDX_DUTY_LOWER, 2'b00};
  assign hit_status = i_avs.address == {`PDPWM_IDX_STATUS, 2'b00};
  assign wr_ctrl    = wr_fire & hit_ctrl;
  assign wr_upper   = wr_fire & hit_upper;
  assign wr_lower   = wr_fire & hit_lower;

  // One wait cycle per request; idle waitrequest is high
  assign wait_next  = ~(req & wait_reg);

  // Status word exposes where the generator stands
  assign status_word = {16'h0000, slot, pulse_idx, active_sel_reg, pending_reg};

  // Write-only registers all read as ones; unmapped reads return zero
  assign readdata_next = (hit_ctrl | hit_upper | hit_lower) ? `PDPWM_READ_ONES :
                         hit_status ? status_word : 32'h00000000;

  // ========================================================================
  // Register next values; only bit 0 of control is storage
  assign period_select_next = wr_ctrl ? i_avs.writedata[`PDPWM_PERIOD_SELECT_BIT]
                                      : period_select_reg;
  assign duty_lower_next    = wr_lower ? i_avs.writedata[7:0] : duty_lower_reg;
  // Upper field is 6 bits; bits 7..6 are never stored
  assign duty_upper_next    = wr_upper ? i_avs.writedata[`PDPWM_DUTY_UPPER_W-1:0]
                                       : duty_upper_reg;
  // Upper write captures both halves at once
  assign pending_duty_next  = wr_upper ? {i_avs.writedata[`PDPWM_DUTY_UPPER_W-1:0],
                                          duty_lower_reg} : pending_duty_reg;
  // A write landing on the period edge stays pending: set beats clear
  assign pending_next       = wr_upper | (pending_reg & ~boundary);

  // ========================================================================
  // Period-synchronous update, so no period ever mixes two duty values
  assign boundary         = unit_tick & (unit_cnt_reg == '1);
  assign active_duty_next = (boundary & pending_reg) ? pending_duty_reg
                                                     : active_duty_reg;
  assign active_sel_next  = boundary ? period_select_reg : active_sel_reg;
  assign unit_cnt_next    = unit_tick ? unit_cnt_reg + 14'h0001 : unit_cnt_reg;

  // ========================================================================
  // Waveform: 64 pulses of 256 units; each gets base share, extras spread
  assign pulse_idx  = unit_cnt_reg[`PDPWM_DUTY_W-1:`PDPWM_SLOT_W];
  assign slot       = unit_cnt_reg[`PDPWM_SLOT_W-1:0];
  // The +64 of the high time is one unit per pulse
  assign base_width = {1'b0, active_duty_reg[`PDPWM_DUTY_W-1:`PDPWM_PULSE_IDX_W]} + 9'h001;
  // Bit reversal scatters the leftover units instead of bunching them
  assign pulse_rev  = {pulse_idx[0], pulse_idx[1], pulse_idx[2],
                       pulse_idx[3], pulse_idx[4], pulse_idx[5]};
  assign extra_unit = pulse_rev < active_duty_reg[`PDPWM_PULSE_IDX_W-1:0];
  assign pulse_width = {1'b0, base_width} + {9'h000, extra_unit};
  // Width above 256 units saturates at a fully high pulse
  assign pwm_next   = {2'b00, slot} < pulse_width;

  // ========================================================================
  // Prescaler: a unit is half the input clock, one or two system clocks
  pdpwm_prescaler u_prescaler (
    .i_clk           (i_clk),
    .i_reset_n       (i_reset_n),
    .i_period_select (active_sel_next),
    .i_restart       (boundary),
    .o_unit_tick     (unit_tick),
    .o_input_clk     (input_clk)
  );

  // ========================================================================
  // Bus slave registers
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wait_reg     <= 1'b1;
      readdata_reg <= 32'h00000000;
    end else begin
      wait_reg     <= wait_next;
      readdata_reg <= (req & wait_reg) ? readdata_next : readdata_reg;
    end
  end

  // Software-visible storage, reset to the documented patterns
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      period_select_reg <= CTRL_RESET[`PDPWM_PERIOD_SELECT_BIT];
      duty_upper_reg    <= UPPER_RESET[`PDPWM_DUTY_UPPER_W-1:0];
      duty_lower_reg    <= `PDPWM_DUTY_LOWER_RESET;
      pending_duty_reg  <= 14'h0000;
      pending_reg       <= 1'b0;
    end else begin
      period_select_reg <= period_select_next;
      duty_upper_reg    <= duty_upper_next;
      duty_lower_reg    <= duty_lower_next;
      pending_duty_reg  <= pending_duty_next;
      pending_reg       <= pending_next;
    end
  end

  // Generator state
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      active_duty_reg <= 14'h0000;
      active_sel_reg  <= 1'b0;
      unit_cnt_reg    <= 14'h0000;
      pwm_reg         <= 1'b0;
    end else begin
      active_duty_reg <= active_duty_next;
      active_sel_reg  <= active_sel_next;
      unit_cnt_reg    <= unit_cnt_next;
      pwm_reg         <= pwm_next;
    end
  end

  assign o_avs_waitrequest = wait_reg;
  assign o_avs_readdata    = readdata_reg;
  assign o_pwm             = pwm_reg;

  // ========================================================================
  // Checking helpers: cycles and high cycles of the running period
  localparam logic [15:0] PER_SHORT_LAST = 16'(`PDPWM_PERIOD_SHORT_CYC - 1);
  localparam logic [15:0] PER_LONG_LAST  = 16'(`PDPWM_PERIOD_LONG_CYC - 1);
  logic [15:0] per_cyc_reg;
  logic [15:0] high_acc_reg;
  logic [15:0] high_units;
  logic [15:0] high_expect;

  assign high_units  = ({2'b00, active_duty_reg} + `PDPWM_DUTY_OFFSET > `PDPWM_UNITS_PER_PERIOD)
                       ? `PDPWM_UNITS_PER_PERIOD
                       : {2'b00, active_duty_reg} + `PDPWM_DUTY_OFFSET;
  assign high_expect = active_sel_reg ? {high_units[14:0], 1'b0} : high_units;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      per_cyc_reg  <= 16'h0000;
      high_acc_reg <= 16'h0000;
    end else begin
      per_cyc_reg  <= boundary ? 16'h0000 : per_cyc_reg + 16'h0001;
      high_acc_reg <= boundary ? 16'h0000 : high_acc_reg + {15'h0000, pwm_next};
    end
  end

  // ========================================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  period_length_a: assert property (
    boundary |-> per_cyc_reg == (active_sel_reg ? PER_LONG_LAST : PER_SHORT_LAST))
    else $error("conversion period length wrong");

  unit_spacing_a: assert property (
    (unit_tick && active_sel_reg && !boundary) |=> !unit_tick ##1 unit_tick)
    else $error("long-period unit is not two clocks");

  ctrl_read_ones_a: assert property (
    (i_avs.read && wait_reg && hit_ctrl) |=> !o_avs_waitrequest && o_avs_readdata[7:0] == 8'hFF)
    else $error("control register read is not all ones");

  ctrl_write_bit0_a: assert property (
    wr_ctrl |=> period_select_reg == $past(i_avs.writedata[0]))
    else $error("control write did not land in bit 0");

  reset_values_a: assert property (
    $past(!i_reset_n) |-> !period_select_reg && duty_upper_reg == 6'h00 &&
                          duty_lower_reg == 8'h00 && !o_pwm && o_avs_waitrequest)
    else $error("reset values wrong");

  upper_latch_a: assert property (
    wr_upper |=> pending_reg && pending_duty_reg ==
                 {$past(i_avs.writedata[5:0]), $past(duty_lower_reg)})
    else $error("upper write did not capture both halves");

  duty_read_ones_a: assert property (
    (i_avs.read && wait_reg && (hit_upper || hit_lower)) |=> o_avs_readdata == 32'h000000FF)
    else $error("duty register read is not all ones");

  pulse_count_a: assert property (
    (unit_tick && slot == 8'hFF && !boundary) |=> pulse_idx == $past(pulse_idx) + 6'h01)
    else $error("pulse index did not advance");

  high_time_a: assert property (
    boundary |-> high_acc_reg + {15'h0000, pwm_next} == high_expect)
    else $error("high time per period wrong");

  pulse_split_a: assert property (
    (slot == 8'hFF && active_duty_reg[13:6] < 8'hFE) |-> !pwm_next)
    else $error("pulse not divided");

  update_sync_a: assert property (
    (active_duty_reg != $past(active_duty_reg)) |-> $past(boundary))
    else $error("duty changed inside a period");

  bus_answer_a: assert property (
    (req && wait_reg) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not one wait cycle");

endmodule

// *** hdl/pdpwm_cfg.svh ***
/*
  Constants of the pulse-division PWM: register indices, reset values, field
  positions and timing counts.
  Assumes it is included by its bare name, before the package and modules.
*/
`ifndef PDPWM_CFG_SVH
`define PDPWM_CFG_SVH

// ==========================================================================
// Register map (indices; byte address is four times the index)
`define PDPWM_ADDR_W              18
`define PDPWM_IDX_CLOCK_CONTROL   16'hFFD0
`define PDPWM_IDX_DUTY_UPPER      16'hFFD1
`define PDPWM_IDX_DUTY_LOWER      16'hFFD2
`define PDPWM_IDX_STATUS          16'hFFD3

// ==========================================================================
// Reset values and fixed read values
`define PDPWM_CLOCK_CONTROL_RESET 8'hFE
`define PDPWM_DUTY_UPPER_RESET    8'hC0
`define PDPWM_DUTY_LOWER_RESET    8'h00
`define PDPWM_READ_ONES           32'h000000FF
`define PDPWM_PERIOD_SELECT_BIT   0
`define PDPWM_DUTY_UPPER_W        6

// ==========================================================================
// Waveform geometry and timing
`define PDPWM_DUTY_W              14
`define PDPWM_PULSE_IDX_W         6
`define PDPWM_SLOT_W              8
`define PDPWM_DUTY_OFFSET         16'h0040
`define PDPWM_UNITS_PER_PERIOD    16'h4000
`define PDPWM_PERIOD_SHORT_CYC    16384
`define PDPWM_PERIOD_LONG_CYC     32768

`endif

// *** hdl/pdpwm_pkg.sv ***
/*
  Types of the pulse-division PWM: the bus request carrier and the duty type.
  Assumes pdpwm_cfg.svh is on the include path.
*/
`include "pdpwm_cfg.svh"

package pdpwm_pkg;

  // ========================================================================
  // Avalon-MM request as driven by the master
  typedef struct packed {
    logic                       read;
    logic                       write;
    logic [`PDPWM_ADDR_W-1:0]   address;
    logic [31:0]                writedata;
    logic [3:0]                 byteenable;
  } pdpwm_avs_req_s;

  typedef logic [`PDPWM_DUTY_W-1:0] pdpwm_duty_t;

endpackage

// *** hdl/pdpwm_prescaler.sv ***
/*
  Input-clock prescaler of the pulse-division PWM. Produces one unit tick per
  half period of the generator input clock (system clock over 2 or over 4).
  Assumes i_period_select is the select in force for the coming cycle and
  i_restart marks the last cycle of a conversion period.
*/
`timescale 1ns/1ps

module pdpwm_prescaler (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_period_select,
  input  wire logic i_restart,
  output logic      o_unit_tick,
  output logic      o_input_clk
);

  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic       tick_next;
  logic       iclk_next;

  // ========================================================================
  // Divider; restarting on the period edge keeps every period phase aligned
  assign cnt_next  = i_restart ? 2'h0 : cnt_reg + 2'h1;
  assign tick_next = i_period_select ? cnt_next[0] : 1'b1;
  assign iclk_next = i_period_select ? cnt_next[1] : cnt_next[0];

  // Registered so the generator sees clean single-cycle ticks
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cnt_reg     <= 2'h0;
      o_unit_tick <= 1'b1;
      o_input_clk <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      o_unit_tick <= tick_next;
      o_input_clk <= iclk_next;
    end
  end

endmodule

// *** tb/pdpwm_lpf_model.sv ***
/*
  Far side of the PWM pin: a low-pass level as an RC filter would settle to,
  and a one-period measurement window for the bench.
  Assumes the pin changes only on rising clock edges.
*/
`timescale 1ns/1ps

module pdpwm_lpf_model (
  input  wire logic        i_clk,
  input  wire logic        i_pwm,
  input  wire logic        i_start,
  input  wire logic [15:0] i_span,
  output logic             o_done,
  output logic [55:0]      o_meas,
  output logic [15:0]      o_level
);
  // ==========================================================================
  // Window state and results
  logic        armed = 1'b0;
  logic        counting = 1'b0;
  logic        prev = 1'b0;
  logic [15:0] n, high, run, maxr, minr;
  logic [7:0]  rises;

  assign o_meas = {high, rises, maxr, minr};

  initial begin
    o_done = 1'b0;
    o_level = 16'h0000;
  end

  // Falling-edge sampling stays clear of the pin's launch edge; the window
  // opens on a falling edge so no pulse is cut short at its front
  always @(negedge i_clk) begin
    o_level <= o_level - (o_level >> 4) + (i_pwm ? 16'h0FFF : 16'h0000);
    prev <= i_pwm;
    if (i_start) begin
      armed <= 1'b1;
      counting <= 1'b0;
      o_done <= 1'b0;
    end else if (armed && prev && !i_pwm) begin
      {armed, counting} <= 2'b01;
      {n, high, run, maxr} <= {16'h0001, 16'h0000, 16'h0000, 16'h0000};
      minr <= 16'hFFFF;
      rises <= 8'h00;
    end else if (counting && n == i_span) begin
      counting <= 1'b0;
      o_done <= 1'b1;
    end else if (counting) begin
      n <= n + 16'h0001;
      if (i_pwm) begin
        high <= high + 16'h0001;
        run <= run + 16'h0001;
      end
      if (i_pwm && !prev) rises <= rises + 8'h01;
      // The run cut off at the window's end is never scored
      if (!i_pwm && prev) begin
        maxr <= (run > maxr) ? run : maxr;
        minr <= (run < minr) ? run : minr;
        run <= 16'h0000;
      end
    end
  end
endmodule

// *** tb/pdpwm_tb_top.sv ***
/*
  Self-checking bench of the pulse-division PWM: Avalon-MM register access
  and whole-period measurements through the filter model.
  Assumes the design files and pdpwm_cfg.svh are compiled first.
*/
`timescale 1ns/1ps
`include "pdpwm_cfg.svh"

module pdpwm_tb_top;
  import pdpwm_pkg::*;
  // ==========================================================================
  // Signals
  logic           i_clk, i_reset_n, chk_rd, start, wait_s, done, done_q;
  pdpwm_avs_req_s avs;
  logic [31:0]    rdata, rd_s;
  logic [15:0]    span_r;
  logic [55:0]    meas, expq[$];
  logic [13:0]    d;
  logic           pwm;
  int             mismatches, checks;
  logic           wait_n_unused_fix;

  pdpwm_top dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_avs(avs),
    .o_avs_waitrequest(wait_n_unused_fix), .o_avs_readdata(rdata), .o_pwm(pwm));
  pdpwm_lpf_model lpf (.i_clk(i_clk), .i_pwm(pwm), .i_start(start), .i_span(span_r),
    .o_done(done), .o_meas(meas), .o_level());

  always #10 i_clk = ~i_clk;

  // ==========================================================================
  // Checking
  task automatic check(input logic [55:0] seen, input logic [55:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Results are taken mid-cycle, where both bus answer and window are settled
  always @(negedge i_clk) begin
    wait_s <= wait_n_unused_fix;
    rd_s <= rdata;
    done_q <= done;
    if (avs.read && chk_rd && wait_n_unused_fix === 1'b0 && expq.size() > 0)
      check({24'h000000, rdata}, expq.pop_front());
    if (done && !done_q && expq.size() > 0)
      check(meas, expq.pop_front());
  end

  // ==========================================================================
  // Bus master: holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic rd, input logic [15:0] idx, input logic [31:0] wd,
                     input logic [3:0] be, input logic chk, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    avs <= '{read: rd, write: !rd, address: {idx, 2'b00}, writedata: wd, byteenable: be};
    chk_rd <= chk;
    do begin
      @(posedge i_clk);
      n++;
    end while (wait_s !== 1'b0 && n < 40);
    if (n >= 40) begin
      mismatches++;
      $display("ERROR %0t: bus answer missing", $time);
    end
    q = rd_s;
    avs <= '0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b0, idx, wd, be, 1'b0, q);
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    expq.push_back({24'h000000, exp});
    bus(1'b1, idx, 32'h00000000, 4'hF, 1'b1, q);
  endtask

  // Poll the pending flag until the period boundary has taken the new duty
  task automatic wait_load();
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h00000001;
    while (q[0] !== 1'b0 && n < 9000) begin
      bus(1'b1, `PDPWM_IDX_STATUS, 32'h00000000, 4'hF, 1'b0, q);
      n++;
    end
    if (n >= 9000) begin
      mismatches++;
      $display("ERROR %0t: duty never loaded", $time);
    end
  endtask

  // Expected {high cycles, rises, longest run, shortest run} for duty d
  function automatic logic [55:0] exp_meas(input logic [13:0] dv, input logic [15:0] u);
    logic [15:0] b;
    b = ({8'h00, dv[13:6]} + 16'h0001) * u;
    return {({2'b00, dv} + 16'h0040) * u, 8'h40, (dv[5:0] != 6'h00) ? b + u : b, b};
  endfunction

  task automatic measure(input logic [13:0] dv, input logic [15:0] u, input logic [15:0] sp);
    int n;
    expq.push_back(exp_meas(dv, u));
    @(posedge i_clk);
    start <= 1'b1;
    span_r <= sp;
    @(posedge i_clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (done !== 1'b1 && n < 40000);
    if (n >= 40000) begin
      mismatches++;
      $display("ERROR %0t: window never closed", $time);
    end
    @(posedge i_clk);
  endtask

  // Random duty with extras on some pulses but not all, no full-high pulse
  task automatic load_duty();
    d[13:6] = 8'($urandom % 250);
    d[5:0] = 6'(2 + $urandom % 61);
    wr(`PDPWM_IDX_DUTY_LOWER, {24'h000000, d[7:0]}, 4'hF);
    wr(`PDPWM_IDX_DUTY_UPPER, {24'h000000, 2'($urandom), d[13:8]}, 4'hF);
    wr(`PDPWM_IDX_DUTY_UPPER, 32'h000000FF, 4'hE);
    wait_load();
  endtask

  // ==========================================================================
  // Watchdog and main sequence
  initial begin
    repeat (120000) @(posedge i_clk);
    mismatches++;
    $display("ERROR %0t: run hung", $time);
    results();
  end

  initial begin
    {i_clk, i_reset_n, chk_rd, start, wait_s, done_q} = 6'b000000;
    avs = '0;
    span_r = 16'h4000;
    mismatches = 0;
    checks = 0;
    void'($urandom(32'h8EE1289C));
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (int i = 0; i < 3; i++)
      rd_chk(`PDPWM_IDX_CLOCK_CONTROL + 16'(i), `PDPWM_READ_ONES);
    rd_chk(`PDPWM_IDX_STATUS + 16'h0001, 32'h00000000);
    measure(14'h0000, 16'h0001, 16'h4000);
    load_duty();
    measure(d, 16'h0001, 16'h4000);
    wr(`PDPWM_IDX_CLOCK_CONTROL, {24'h000000, 7'($urandom), 1'b1}, 4'hF);
    load_duty();
    measure(d, 16'h0002, 16'h8000);
    rd_chk(`PDPWM_IDX_CLOCK_CONTROL, `PDPWM_READ_ONES);
    results();
  end
endmodule
